// ### core/psrf_pkg.sv
// Constants for the position sensor response framer
package psrf_pkg;
	// APB register offsets
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STAT_OFS   = 8'h04;
	localparam logic [7:0] MARK_OFS   = 8'h08;
	// Control register fields and reset values
	localparam int         CTRL_NODE_LSB = 0;
	localparam int         CTRL_EN_BIT   = 2;
	localparam logic [1:0] NODE_RST      = 2'h0;
	localparam logic       EN_RST        = 1'b1;
	// Status register fields
	localparam int         STAT_CNT_LSB  = 9;
	localparam int         STAT_MARK_BIT = 13;
	localparam int         STAT_BUSY_BIT = 14;
	// Status character bit positions
	localparam int         ST_ERR   = 0;
	localparam int         ST_TAPE  = 1;
	localparam int         ST_QLSB  = 2;
	localparam int         ST_ALSB  = 4;
	localparam int         ST_MARK  = 6;
	localparam int         ST_DIAG  = 7;
	localparam int         ST_NINTH = 8;
	// Request character layout
	localparam logic [3:0] REQ_SYNC  = 4'hb;
	localparam int         REQ_MARK  = 2;
	localparam int         REQ_DIAG  = 3;
	localparam int         REQ_SHOT  = 4;
	// ASCII characters
	localparam logic [7:0] ASC_E  = 8'h45;
	localparam logic [7:0] ASC_0  = 8'h30;
	localparam logic [7:0] ASC_9  = 8'h39;
	localparam logic [7:0] ASC_A  = 8'h41;
	localparam logic [7:0] ASC_G  = 8'h47;
	// Reading quality thresholds in percent
	localparam logic [6:0] Q_HI   = 7'h4b;
	localparam logic [6:0] Q_MID  = 7'h32;
	localparam logic [6:0] Q_LO   = 7'h19;
	// Diagnostic codes
	localparam logic [3:0] DIAG_IF    = 4'h1;
	localparam logic [3:0] DIAG_RANGE = 4'h5;
	localparam logic [3:0] DIAG_LABEL = 4'h9;
	// Frame and store sizes
	localparam int         FRAME_LEN  = 8;
	localparam logic [2:0] FRAME_LAST = 3'h7;
	localparam int         DIAG_DEPTH = 8;
	localparam logic [3:0] DIAG_FULL  = 4'h8;
	// Transmit state
	typedef enum logic {
		PSRF_IDLE = 1'b0,
		PSRF_SEND = 1'b1
	} psrf_state_e;
endpackage

// ### core/psrf_framer.sv
// Response framer: request decode, marker and diagnostic stores, APB registers
`timescale 1ns/10ps
module psrf_framer (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Received request character
	input  wire logic        req_valid,
	input  wire logic [8:0]  req_char,
	// Transmit character stream
	output logic             tx_valid,
	input  wire logic        tx_ready,
	output logic      [8:0]  tx_char,
	// Measurement state
	input  wire logic        fault,
	input  wire logic        no_decode,
	input  wire logic [6:0]  quality_pct,
	input  wire logic [23:0] position,
	// Decoded label
	input  wire logic        label_valid,
	input  wire logic [7:0]  label_c0,
	input  wire logic [7:0]  label_c1,
	input  wire logic [7:0]  label_c2,
	// Diagnostic events
	input  wire logic        diag_valid,
	input  wire logic [3:0]  diag_code
);

	// Letter A to G test
	function automatic logic is_ag(input logic [7:0] c);
		is_ag = (c >= psrf_pkg::ASC_A) && (c <= psrf_pkg::ASC_G);
	endfunction

	// Widen a data character to nine bits
	function automatic logic [8:0] ch9(input logic [7:0] c);
		ch9 = {1'b0, c};
	endfunction

	localparam int FRAME_LEN_C  = psrf_pkg::FRAME_LEN;
	localparam int DIAG_DEPTH_C = psrf_pkg::DIAG_DEPTH;

	psrf_pkg::psrf_state_e state_reg;        // Transmit state
	logic [1:0]            node_addr_reg;    // Configured node address
	logic                  enable_reg;       // Request acceptance enable
	logic [8:0]            frame_reg [FRAME_LEN_C]; // Outgoing characters
	logic [2:0]            idx_reg;          // Characters already sent
	logic [8:0]            last_status_reg;  // Status of last frame
	logic                  marker_held_reg;  // Marker content stored
	logic [23:0]           marker_reg;       // Stored marker characters
	logic [3:0]            diag_mem [DIAG_DEPTH_C]; // Diagnostic store
	logic [2:0]            diag_wr_reg;      // Store write pointer
	logic [2:0]            diag_rd_reg;      // Store read pointer
	logic [3:0]            diag_cnt_reg;     // Stored entry count
	logic [31:0]           prdata_reg;       // Read data, setup phase
	logic                  pslverr_reg;      // Error, setup phase

	// Decode helpers
	logic        accept;         // Valid addressed request taken
	logic        srv_diag;       // Diagnostic request served
	logic        srv_mark;       // Marker request served
	logic        label_ok;       // Marker label recognised
	logic        code_ok;        // Known diagnostic code
	logic        push;           // Store write
	logic        pop;            // Store read
	logic        tx_fire;        // Character handed over
	logic [1:0]  quality_code;   // Encoded reading quality
	logic [3:0]  cnt_after;      // Entry count after this frame
	logic        mark_after;     // Marker held after this frame
	logic [23:0] data_sel;       // Selected data bytes 1 to 3
	logic [8:0]  status_char;    // Status byte of new frame
	logic [8:0]  xor_char;       // Check byte
	logic        apb_wr;         // APB write access
	logic        apb_setup;      // APB setup phase

	// Request decode: fixed pattern, own address, idle framer
	assign accept = req_valid && enable_reg && (state_reg == psrf_pkg::PSRF_IDLE)
		&& (req_char[8:5] == psrf_pkg::REQ_SYNC) && (req_char[1:0] == node_addr_reg);

	// Priority: diagnostics, then marker, then single shot or position
	assign srv_diag = accept && req_char[psrf_pkg::REQ_DIAG];
	assign srv_mark = accept && !req_char[psrf_pkg::REQ_DIAG]
		&& req_char[psrf_pkg::REQ_MARK];

	// Marker label check
	assign label_ok = label_valid && is_ag(label_c0) && is_ag(label_c1)
		&& (label_c2 >= psrf_pkg::ASC_0) && (label_c2 <= psrf_pkg::ASC_9);

	// Only the documented codes enter the store
	assign code_ok = ((diag_code >= psrf_pkg::DIAG_IF) && (diag_code <= psrf_pkg::DIAG_RANGE))
		|| (diag_code == psrf_pkg::DIAG_LABEL);

	// Store traffic; a full store drops new events unless a read pops an entry in the same cycle
	assign pop  = srv_diag && (diag_cnt_reg != 4'h0);
	assign push = diag_valid && code_ok && ((diag_cnt_reg != psrf_pkg::DIAG_FULL) || pop);

	// Count and marker state as reported in the new frame
	always_comb begin
		cnt_after = diag_cnt_reg;
		if (pop) begin
			cnt_after = diag_cnt_reg - 4'h1;
		end
		mark_after = marker_held_reg && !srv_mark;
	end

	// Reading quality bands
	always_comb begin
		if (quality_pct > psrf_pkg::Q_HI) begin
			quality_code = 2'h0;
		end else if (quality_pct > psrf_pkg::Q_MID) begin
			quality_code = 2'h1;
		end else if (quality_pct >= psrf_pkg::Q_LO) begin
			quality_code = 2'h2;
		end else begin
			quality_code = 2'h3;
		end
	end

	// Status byte assembly
	always_comb begin
		status_char                                 = 9'h000;
		status_char[psrf_pkg::ST_ERR]               = fault;
		status_char[psrf_pkg::ST_TAPE]              = no_decode;
		status_char[psrf_pkg::ST_QLSB +: 2]         = quality_code;
		status_char[psrf_pkg::ST_ALSB +: 2]         = node_addr_reg;
		status_char[psrf_pkg::ST_MARK]              = mark_after;
		status_char[psrf_pkg::ST_DIAG]              = (cnt_after != 4'h0);
		status_char[psrf_pkg::ST_NINTH]             = 1'b0;
	end

	// Data bytes by served request
	always_comb begin
		if (srv_diag) begin
			if (pop) begin
				data_sel = {psrf_pkg::ASC_E, psrf_pkg::ASC_0,
					psrf_pkg::ASC_0 + {4'h0, diag_mem[diag_rd_reg]}};
			end else begin
				data_sel = {psrf_pkg::ASC_E, psrf_pkg::ASC_0, psrf_pkg::ASC_0};
			end
		end else if (srv_mark) begin
			if (marker_held_reg) begin
				data_sel = marker_reg;
			end else begin
				data_sel = {psrf_pkg::ASC_E, psrf_pkg::ASC_0, psrf_pkg::ASC_0};
			end
		end else begin
			data_sel = position;
		end
	end

	// Check byte over bytes 0 to 3
	assign xor_char = status_char ^ ch9(data_sel[23:16]) ^ ch9(data_sel[15:8])
		^ ch9(data_sel[7:0]);

	// Transmit handshake
	assign tx_fire  = (state_reg == psrf_pkg::PSRF_SEND) && tx_ready;
	assign tx_valid = (state_reg == psrf_pkg::PSRF_SEND);
	assign tx_char  = frame_reg[0];

	// Framer state: one frame of eight per accepted request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= psrf_pkg::PSRF_IDLE;
			idx_reg   <= 3'h0;
		end else begin
			unique case (state_reg)
				psrf_pkg::PSRF_IDLE: begin
					if (accept) begin
						state_reg <= psrf_pkg::PSRF_SEND;
						idx_reg   <= 3'h0;
					end
				end
				psrf_pkg::PSRF_SEND: begin
					if (tx_fire) begin
						idx_reg <= idx_reg + 3'h1;
						if (idx_reg == psrf_pkg::FRAME_LAST) begin
							state_reg <= psrf_pkg::PSRF_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Frame shift register: load on accept, shift per character
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < FRAME_LEN_C; i++) begin
				frame_reg[i] <= 9'h000;
			end
		end else if (accept) begin
			frame_reg[0] <= status_char;
			frame_reg[1] <= ch9(data_sel[23:16]);
			frame_reg[2] <= ch9(data_sel[15:8]);
			frame_reg[3] <= ch9(data_sel[7:0]);
			frame_reg[4] <= xor_char;
			frame_reg[5] <= ch9(data_sel[23:16]);
			frame_reg[6] <= ch9(data_sel[15:8]);
			frame_reg[7] <= ch9(data_sel[7:0]);
		end else if (tx_fire) begin
			for (int i = 0; i < FRAME_LEN_C - 1; i++) begin
				frame_reg[i] <= frame_reg[i + 1];
			end
			frame_reg[FRAME_LEN_C - 1] <= 9'h000;
		end
	end

	// Last status byte kept for software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_status_reg <= 9'h000;
		end else if (accept) begin
			last_status_reg <= status_char;
		end
	end

	// Marker store: a fresh read wins over a same-cycle fetch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			marker_held_reg <= 1'b0;
			marker_reg      <= 24'h000000;
		end else if (label_ok) begin
			marker_held_reg <= 1'b1;
			marker_reg      <= {label_c0, label_c1, label_c2};
		end else if (srv_mark) begin
			marker_held_reg <= 1'b0;
		end
	end

	// Diagnostic store contents
	always_ff @(posedge pclk) begin
		if (push) begin
			diag_mem[diag_wr_reg] <= diag_code;
		end
	end

	// Diagnostic store pointers and count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			diag_wr_reg  <= 3'h0;
			diag_rd_reg  <= 3'h0;
			diag_cnt_reg <= 4'h0;
		end else begin
			if (push) begin
				diag_wr_reg <= diag_wr_reg + 3'h1;
			end
			if (pop) begin
				diag_rd_reg <= diag_rd_reg + 3'h1;
			end
			diag_cnt_reg <= diag_cnt_reg + {3'h0, push} - {3'h0, pop};
		end
	end

	// APB phases; the slave never inserts wait states
	assign apb_setup = psel && !penable;
	assign apb_wr    = psel && penable && pwrite && (paddr == psrf_pkg::CTRL_OFS);
	assign pready    = 1'b1;
	assign prdata    = prdata_reg;
	assign pslverr   = pslverr_reg && psel && penable;

	// Control register: node address and enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			node_addr_reg <= psrf_pkg::NODE_RST;
			enable_reg    <= psrf_pkg::EN_RST;
		end else if (apb_wr) begin
			node_addr_reg <= pwdata[psrf_pkg::CTRL_NODE_LSB +: 2];
			enable_reg    <= pwdata[psrf_pkg::CTRL_EN_BIT];
		end
	end

	// Read data and error captured in the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg  <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end else if (apb_setup) begin
			prdata_reg  <= 32'h00000000;
			pslverr_reg <= 1'b0;
			unique case (paddr)
				psrf_pkg::CTRL_OFS: begin
					prdata_reg[psrf_pkg::CTRL_NODE_LSB +: 2] <= node_addr_reg;
					prdata_reg[psrf_pkg::CTRL_EN_BIT]        <= enable_reg;
				end
				psrf_pkg::STAT_OFS: begin
					if (!pwrite) begin
						prdata_reg[8:0]                         <= last_status_reg;
						prdata_reg[psrf_pkg::STAT_CNT_LSB +: 4] <= diag_cnt_reg;
						prdata_reg[psrf_pkg::STAT_MARK_BIT]     <= marker_held_reg;
						prdata_reg[psrf_pkg::STAT_BUSY_BIT]     <= tx_valid;
					end else begin
						pslverr_reg <= 1'b1;
					end
				end
				psrf_pkg::MARK_OFS: begin
					if (!pwrite) begin
						prdata_reg[23:0] <= marker_reg;
					end else begin
						pslverr_reg <= 1'b1;
					end
				end
				default: begin
					pslverr_reg <= 1'b1;
				end
			endcase
		end
	end

endmodule // psrf_framer

// ### testbench/psrf_chk.sv
// Port checker for the response framer
`timescale 1ns/10ps
module psrf_chk (
	// Clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// APB
	input wire logic [7:0] paddr,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pslverr,
	// Response stream
	input wire logic       tx_valid,
	input wire logic       tx_ready,
	input wire logic [8:0] tx_char,
	// Measurement state
	input wire logic       fault,
	input wire logic       no_decode,
	input wire logic [6:0] quality_pct
);
	logic [3:0] cnt_reg;        // Characters taken in this frame
	logic [8:0] keep_reg [0:3]; // Bytes 0 to 3 of this frame
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Quality band from percent
	function automatic logic [1:0] band(input logic [6:0] q);
		band = q > 7'h4b ? 2'h0 : q > 7'h32 ? 2'h1 : q > 7'h18 ? 2'h2 : 2'h3;
	endfunction
	// Count taken characters and keep the first four
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 4'h0;
			for (int i = 0; i < 4; i++) keep_reg[i] <= 9'h000;
		end else if (!tx_valid) begin
			cnt_reg <= 4'h0;
		end else if (tx_ready) begin
			cnt_reg <= cnt_reg + 4'h1;
			if (cnt_reg < 4'h4) keep_reg[cnt_reg[1:0]] <= tx_char;
		end
	end
	chk_ninth_low: assert property (tx_valid |-> !tx_char[8]) else $error("ninth bit set");
	chk_char_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_char))
		else $error("character changed while stalled");
	chk_frame_len: assert property ($fell(tx_valid) |-> cnt_reg == 4'h8) else $error("frame not 8");
	chk_xor_byte: assert property (tx_valid && cnt_reg == 4'h4 |->
		tx_char == (keep_reg[0] ^ keep_reg[1] ^ keep_reg[2] ^ keep_reg[3])) else $error("bad xor");
	chk_repeat_data: assert property (tx_valid && cnt_reg > 4'h4 && cnt_reg < 4'h8 |->
		tx_char == keep_reg[cnt_reg[1:0]]) else $error("bad repeat");
	chk_err_flag: assert property ($rose(tx_valid) && $stable(fault) |-> tx_char[0] == fault)
		else $error("bad fault bit");
	chk_tape_flag: assert property ($rose(tx_valid) && $stable(no_decode) |-> tx_char[1] == no_decode)
		else $error("bad tape bit");
	chk_quality_band: assert property ($rose(tx_valid) && $stable(quality_pct) |->
		tx_char[3:2] == band(quality_pct)) else $error("bad quality");
	chk_unmapped_err: assert property (psel && penable && paddr == 8'h0c |-> pslverr) else $error("no slverr");
endmodule // psrf_chk
bind psrf_framer psrf_chk u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pslverr(pslverr), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_char(tx_char),
	.fault(fault), .no_decode(no_decode), .quality_pct(quality_pct));

// ### testbench/psrf_host.sv
// Polling host model: sends requests, collects responses
`timescale 1ns/10ps
module psrf_host (
	// Clock and pacing
	input  wire logic       pclk,
	input  wire logic       slow,
	// Request and response characters
	output logic            req_valid,
	output logic      [8:0] req_char,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	input  wire logic [8:0] tx_char
);
	logic [8:0] frame [0:7]; // Last response
	int         got;         // Characters taken
	initial begin
		req_valid = 1'b0;
		req_char  = 9'h0;
	end
	// Clear on a request, take characters; stall every other cycle when slow
	always @(posedge pclk) begin
		if (req_valid) begin
			got = 0;
			for (int k = 0; k < 8; k++) frame[k] = 9'hx;
		end else if (tx_valid && tx_ready && got < 8) begin
			frame[got] = tx_char;
			got++;
		end
		tx_ready <= slow ? !tx_ready : 1'b1;
	end
	// One request, then wait for eight characters
	task automatic poll(input logic [2:0] sel, input logic [1:0] addr);
		int n;
		@(posedge pclk);
		req_valid <= 1'b1;
		req_char  <= {4'hb, sel, addr};
		@(posedge pclk);
		req_valid <= 1'b0;
		req_char  <= ~req_char;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (got < 8 && n < 40);
	endtask
endmodule // psrf_host

// ### testbench/tb.sv
// Self-checking testbench for the response framer
`timescale 1ns/10ps
module tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
	logic [7:0]  paddr, label_c0, label_c1, label_c2;
	logic [31:0] pwdata, prdata;
	logic        req_valid, tx_valid, tx_ready, fault, no_decode, label_valid, diag_valid;
	logic [8:0]  req_char, tx_char;
	logic [6:0]  quality_pct;
	logic [23:0] position;
	logic [3:0]  diag_code;
	int          bad_count, cmp_count, cyc;
	psrf_framer u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.req_valid(req_valid), .req_char(req_char), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_char(tx_char), .fault(fault), .no_decode(no_decode), .quality_pct(quality_pct),
		.position(position), .label_valid(label_valid), .label_c0(label_c0), .label_c1(label_c1),
		.label_c2(label_c2), .diag_valid(diag_valid), .diag_code(diag_code));
	psrf_host u_host (.pclk(pclk), .slow(slow), .req_valid(req_valid), .req_char(req_char),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_char(tx_char));
	// Clock and hang guard
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc > 20000) begin
			bad_count++;
			complete_run();
		end
	end
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// APB transfer, held until pready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic err);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	// Compare a full frame against status and data
	task automatic frame(input string what, input logic [8:0] st, input logic [23:0] d);
		logic [8:0] e [0:7];
		e[0] = st;
		e[1] = {1'b0, d[23:16]};
		e[2] = {1'b0, d[15:8]};
		e[3] = {1'b0, d[7:0]};
		e[4] = e[0] ^ e[1] ^ e[2] ^ e[3];
		for (int i = 5; i < 8; i++) e[i] = e[i - 4];
		for (int i = 0; i < 8; i++) check(what, 32'(e[i]), 32'(u_host.frame[i]));
	endtask
	// One-cycle label pulse
	task automatic label(input logic [23:0] s);
		@(posedge pclk);
		label_valid <= 1'b1;
		{label_c0, label_c1, label_c2} <= s;
		@(posedge pclk);
		label_valid <= 1'b0;
	endtask
	task automatic t_regs;
		logic [31:0] rd;
		logic        err;
		apb(1'b0, 8'h00, 32'h0, rd, err);
		check("ctrl reset", 32'h4, rd);
		apb(1'b0, 8'h0c, 32'h0, rd, err);
		check("unmapped", 32'h1, 32'(err));
		apb(1'b1, 8'h04, 32'h0, rd, err);
		check("ro write", 32'h1, 32'(err));
		apb(1'b1, 8'h00, 32'h1, rd, err);
		u_host.poll(3'h0, 2'h1);
		check("disabled", 32'h0, 32'(u_host.got));
		apb(1'b1, 8'h00, 32'h4, rd, err);
		u_host.poll(3'h0, 2'h1);
		check("other node", 32'h0, 32'(u_host.got));
		$display("t_regs done");
	endtask
	task automatic t_status;
		logic [31:0] rd;
		logic        err;
		logic [6:0]  q [0:3];
		q = '{7'h4c, 7'h4b, 7'h32, 7'h18};
		for (int i = 0; i < 4; i++) begin
			fault       <= i[1];
			no_decode   <= i[0];
			quality_pct <= q[i];
			position    <= {8'h5a, 8'(i), 8'hc3};
			slow        <= i[0];
			apb(1'b1, 8'h00, 32'h4 | 32'(i), rd, err);
			u_host.poll(i[0] ? 3'h4 : 3'h0, i[1:0]);
			frame("status", {3'h0, i[1:0], i[1:0], i[0], i[1]}, {8'h5a, 8'(i), 8'hc3});
		end
		apb(1'b1, 8'h00, 32'h4, rd, err);
		{fault, no_decode, quality_pct} <= {2'h0, 7'h50};
		$display("t_status done");
	endtask
	task automatic t_marker;
		logic [31:0] rd;
		logic        err;
		u_host.poll(3'h1, 2'h0);
		frame("empty marker", 9'h000, 24'h453030);
		label(24'h414833);
		u_host.poll(3'h0, 2'h0);
		frame("bad label", 9'h000, position);
		label(24'h414233);
		u_host.poll(3'h0, 2'h0);
		frame("marker held", 9'h040, position);
		apb(1'b0, 8'h04, 32'h0, rd, err);
		check("status reg", 32'h00002040, rd);
		apb(1'b0, 8'h08, 32'h0, rd, err);
		check("marker reg", 32'h00414233, rd);
		u_host.poll(3'h1, 2'h0);
		frame("marker data", 9'h000, 24'h414233);
		label(24'h474731);
		u_host.poll(3'h0, 2'h0);
		frame("marker again", 9'h040, position);
		$display("t_marker done");
	endtask
	task automatic t_diag;
		logic [3:0] c [0:6];
		c = '{4'h1, 4'h7, 4'h2, 4'h3, 4'h4, 4'h5, 4'h9};
		for (int i = 0; i < 7; i++) begin
			@(posedge pclk);
			diag_valid <= 1'b1;
			diag_code  <= c[i];
		end
		@(posedge pclk);
		diag_valid <= 1'b0;
		u_host.poll(3'h0, 2'h0);
		frame("diag held", 9'h0c0, position);
		for (int k = 0; k < 6; k++) begin
			u_host.poll(3'h3, 2'h0);
			frame("diag entry", {1'b0, k < 5, 7'h40}, {16'h4530, 4'h3, c[k > 0 ? k + 1 : 0]});
		end
		u_host.poll(3'h2, 2'h0);
		frame("diag empty", 9'h040, 24'h453030);
		$display("t_diag done");
	endtask
	initial begin
		{presetn, psel, penable, pwrite, slow, label_valid, diag_valid, fault, no_decode} = '0;
		{paddr, pwdata, label_c0, label_c1, label_c2, diag_code} = '0;
		quality_pct = 7'h50;
		position = 24'h0a1b2c;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_status();
		t_marker();
		t_diag();
		complete_run();
	end
endmodule // tb
